//--- include/dmc_pkg.sv
// ============================================================
// shared constants and carriers of the cache block
package dmc_pkg;
    // ============================================================
    // address split
    localparam int ADDR_W = 32;           // physical reference address width
    localparam int DATA_W = 32;           // one word
    localparam int BE_W = 4;              // byte lanes of a word
    localparam int I_TAG_LSB = 4;         // instruction line is 16 bytes
    localparam int D_TAG_LSB = 2;         // data line is one word
    localparam int I_TAG_W = ADDR_W - I_TAG_LSB;
    localparam int D_TAG_W = ADDR_W - D_TAG_LSB;
    localparam int QUAD_WORDS = 4;        // words per instruction line
    // ============================================================
    // sizes: default 16kB I / 4kB D, alternative 8kB / 8kB
    localparam int IC_LINES_MAX = 1024;   // 16kB of 16-byte lines
    localparam int IC_IDX_W = 10;
    localparam int DC_WORDS_MAX = 2048;   // 8kB of words
    localparam int DC_IDX_W = 11;
    localparam logic [IC_IDX_W-1:0] IC_MASK_DEF = 10'h3FF;  // 1024 lines
    localparam logic [IC_IDX_W-1:0] IC_MASK_ALT = 10'h1FF;  // 512 lines
    localparam logic [DC_IDX_W-1:0] DC_MASK_DEF = 11'h3FF;  // 1024 words
    localparam logic [DC_IDX_W-1:0] DC_MASK_ALT = 11'h7FF;  // 2048 words
    localparam logic [BE_W-1:0] BE_FULL = 4'hF;
    localparam logic [1:0] FILL_LAST = 2'h3;
    // ============================================================
    // write buffer
    localparam int WB_DEPTH = 4;
    localparam int WB_PTR_W = 2;
    localparam logic [2:0] WB_CNT_FULL = 3'h4;
    // one pending memory write
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [BE_W-1:0] be;
    } dmc_wr_t;
    // write buffer state
    typedef struct packed {
        dmc_wr_t [WB_DEPTH-1:0] ent;
        logic [WB_PTR_W-1:0] wr_ptr;
        logic [WB_PTR_W-1:0] rd_ptr;
        logic [2:0] cnt;
    } dmc_wb_st_t;
    // ============================================================
    // controller
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_LOOKUP = 3'h1,
        ST_DFILL = 3'h2,
        ST_IFILL = 3'h3
    } dmc_state_t;
    typedef struct packed {
        dmc_state_t st;
        logic i_pend;                     // fetch not yet answered or its quad fill not done
        logic i_miss;                     // fetch lookup missed
        logic d_pend;                     // data reference not yet answered
        logic [ADDR_W-1:0] i_addr;
        logic [ADDR_W-1:0] d_addr;
        logic d_we;
        logic [BE_W-1:0] d_be;
        logic d_unc;
        logic [DATA_W-1:0] d_wdata;
        logic [1:0] fill_cnt;             // word count of a quad fill
        logic i_valid;
        logic [DATA_W-1:0] i_data;
        logic d_valid;
        logic [DATA_W-1:0] d_data;
    } dmc_ctl_t;
endpackage : dmc_pkg

//--- hw/dmc_wbuf.sv
`timescale 1ns/100ps
// ============================================================
// four-entry write buffer between store path and memory
module dmc_wbuf (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input dmc_pkg::dmc_wr_t in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output dmc_pkg::dmc_wr_t out_data_o,
    output logic empty_o
);
    dmc_pkg::dmc_wb_st_t wb_reg;          // whole buffer state
    dmc_pkg::dmc_wb_st_t wb_next;
    logic push;                           // entry taken this cycle
    logic pop;                            // head handed to memory

    // ============================================================
    // handshakes
    assign in_ready_o = (wb_reg.cnt != dmc_pkg::WB_CNT_FULL);
    assign out_valid_o = (wb_reg.cnt != 3'h0);
    assign empty_o = (wb_reg.cnt == 3'h0);
    assign out_data_o = wb_reg.ent[wb_reg.rd_ptr];  // head, from flops
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // next state: entries leave in arrival order
    always_comb begin
        wb_next = wb_reg;
        if (push) begin
            wb_next.ent[wb_reg.wr_ptr] = in_data_i;
            wb_next.wr_ptr = wb_reg.wr_ptr + 2'h1;
        end
        if (pop) begin
            wb_next.rd_ptr = wb_reg.rd_ptr + 2'h1;
        end
        case ({push, pop})
            2'b10: wb_next.cnt = wb_reg.cnt + 3'h1;
            2'b01: wb_next.cnt = wb_reg.cnt - 3'h1;
            default: wb_next.cnt = wb_reg.cnt;
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            wb_reg <= '0;
        end else begin
            wb_reg <= wb_next;
        end
    end

    // ============================================================
    // checks
    a_wb_depth_bound: assert property (
        @(posedge CLK_I) disable iff (!NRST_I)
        (wb_reg.cnt == dmc_pkg::WB_CNT_FULL && !out_ready_i) |-> !in_ready_o ##1
            (wb_reg.cnt == dmc_pkg::WB_CNT_FULL))
        else $error("write buffer exceeded four entries");
    a_wb_fifo_head: assert property (
        @(posedge CLK_I) disable iff (!NRST_I)
        (push && empty_o) |=> (out_data_o == $past(in_data_i)))
        else $error("first write not at buffer head");
endmodule : dmc_wbuf

//--- hw/dmc_cache_top.sv
`timescale 1ns/100ps
// Summary of operation
// - split address into index and tag
// - read word and tag together
// - hit only on tag match, else miss
// - separate instruction and data caches
// - direct mapped, one location per address
// - index and tag use physical address
// - cacheable store writes cache and memory, save on a partial miss
// - uncacheable store goes to memory only
// - write buffer takes store in one cycle
// - four pending writes, drained in order
// - partial store first looks up cache
// - partial hit merges bytes into cache
// - partial hit sends full merged word
// - partial miss: memory only, cache untouched
// - instruction lines are four words, quad fill
// - data cache tags every word
// - default 16k/4k, alternative 8k/8k sizes
module dmc_cache_top (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic ALT_SIZE_I,                 // 8kB/8kB organisation
    input wire logic IF_REQ_I,                   // instruction fetch
    input wire logic [31:0] IF_ADDR_I,           // physical fetch address
    output logic IF_VALID_O,
    output logic [31:0] IF_DATA_O,
    input wire logic DC_REQ_I,                   // data reference
    input wire logic DC_WE_I,
    input wire logic [3:0] DC_BE_I,
    input wire logic DC_UNCACHED_I,
    input wire logic [31:0] DC_ADDR_I,           // physical data address
    input wire logic [31:0] DC_WDATA_I,
    output logic DC_VALID_O,
    output logic [31:0] DC_RDATA_O,
    output logic CORE_STALL_O,
    output logic MR_REQ_O,                       // memory read request
    output logic MR_QUAD_O,
    output logic [31:0] MR_ADDR_O,
    input wire logic MR_ACK_I,
    input wire logic [31:0] MR_DATA_I,
    output logic MW_REQ_O,                       // memory write request
    output logic [31:0] MW_ADDR_O,
    output logic [31:0] MW_DATA_O,
    output logic [3:0] MW_BE_O,
    input wire logic MW_ACK_I
);
    // ============================================================
    // storage: one array per cache, no second way anywhere
    logic [31:0] ic_data [dmc_pkg::IC_LINES_MAX*dmc_pkg::QUAD_WORDS];
    logic [dmc_pkg::I_TAG_W-1:0] ic_tag [dmc_pkg::IC_LINES_MAX];
    logic [dmc_pkg::IC_LINES_MAX-1:0] ic_vld;
    logic [31:0] dc_data [dmc_pkg::DC_WORDS_MAX];
    logic [dmc_pkg::D_TAG_W-1:0] dc_tag [dmc_pkg::DC_WORDS_MAX];
    logic [dmc_pkg::DC_WORDS_MAX-1:0] dc_vld;

    dmc_pkg::dmc_ctl_t ctl_reg;                  // controller state
    dmc_pkg::dmc_ctl_t ctl_next;
    // lookup read registers
    logic [31:0] i_rd_data;
    logic [dmc_pkg::I_TAG_W-1:0] i_rd_tag;
    logic i_rd_vld;
    logic [31:0] d_rd_data;
    logic [dmc_pkg::D_TAG_W-1:0] d_rd_tag;
    logic d_rd_vld;
    // index and tag of the addresses
    logic [dmc_pkg::IC_IDX_W-1:0] ic_mask;
    logic [dmc_pkg::DC_IDX_W-1:0] dc_mask;
    logic [dmc_pkg::IC_IDX_W-1:0] i_idx_in;      // from incoming address
    logic [dmc_pkg::DC_IDX_W-1:0] d_idx_in;
    logic [dmc_pkg::IC_IDX_W-1:0] i_idx;         // from held address
    logic [dmc_pkg::DC_IDX_W-1:0] d_idx;
    logic accept;                                // new reference taken
    logic i_hit;
    logic d_hit;
    logic d_partial;
    logic [31:0] merged;                         // store bytes over cache word
    // cache write strobes
    logic dc_we;
    logic [31:0] dc_wdata;
    logic ic_we;
    logic ic_tag_we;
    // write buffer link
    logic wb_in_valid;
    logic wb_in_ready;
    dmc_pkg::dmc_wr_t wb_in;
    dmc_pkg::dmc_wr_t wb_out;
    logic wb_empty;

    // ============================================================
    // address split and size selection
    assign ic_mask = ALT_SIZE_I ? dmc_pkg::IC_MASK_ALT : dmc_pkg::IC_MASK_DEF;
    assign dc_mask = ALT_SIZE_I ? dmc_pkg::DC_MASK_ALT : dmc_pkg::DC_MASK_DEF;
    // physical address straight from translation, no virtual index
    assign i_idx_in = IF_ADDR_I[13:4] & ic_mask;
    assign d_idx_in = DC_ADDR_I[12:2] & dc_mask;
    assign i_idx = ctl_reg.i_addr[13:4] & ic_mask;
    assign d_idx = ctl_reg.d_addr[12:2] & dc_mask;
    assign accept = (ctl_reg.st == dmc_pkg::ST_IDLE) && (IF_REQ_I || DC_REQ_I);

    // ============================================================
    // arrays: word and tag read on the same edge
    // full upper bits are kept as tag, so a size switch never aliases
    always_ff @(posedge CLK_I) begin
        if (accept) begin
            i_rd_data <= ic_data[{i_idx_in, IF_ADDR_I[3:2]}];
            i_rd_tag <= ic_tag[i_idx_in];
            d_rd_data <= dc_data[d_idx_in];
            d_rd_tag <= dc_tag[d_idx_in];
        end
        if (ic_we) begin
            ic_data[{i_idx, ctl_reg.fill_cnt}] <= MR_DATA_I;
        end
        if (ic_tag_we) begin
            ic_tag[i_idx] <= ctl_reg.i_addr[31:4];
        end
        if (dc_we) begin
            dc_data[d_idx] <= dc_wdata;
            dc_tag[d_idx] <= ctl_reg.d_addr[31:2];
        end
    end

    // valid flags, cleared by reset
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ic_vld <= '0;
            dc_vld <= '0;
            i_rd_vld <= 1'b0;
            d_rd_vld <= 1'b0;
        end else begin
            if (accept) begin
                i_rd_vld <= ic_vld[i_idx_in];
                d_rd_vld <= dc_vld[d_idx_in];
            end
            if (ic_tag_we) begin
                ic_vld[i_idx] <= 1'b1;
            end
            if (dc_we) begin
                dc_vld[d_idx] <= 1'b1;
            end
        end
    end

    // ============================================================
    // compare and merge
    assign i_hit = i_rd_vld && (i_rd_tag == ctl_reg.i_addr[31:4]);
    assign d_hit = d_rd_vld && (d_rd_tag == ctl_reg.d_addr[31:2]);
    assign d_partial = (ctl_reg.d_be != dmc_pkg::BE_FULL);
    for (genvar b = 0; b < dmc_pkg::BE_W; b++) begin : g_merge
        // new bytes over the looked-up word
        assign merged[8*b+7:8*b] = ctl_reg.d_be[b] ? ctl_reg.d_wdata[8*b+7:8*b]
                                                   : d_rd_data[8*b+7:8*b];
    end

    // ============================================================
    // controller
    always_comb begin
        ctl_next = ctl_reg;
        ctl_next.i_valid = 1'b0;                 // answers are pulses
        ctl_next.d_valid = 1'b0;
        dc_we = 1'b0;
        dc_wdata = merged;
        ic_we = 1'b0;
        ic_tag_we = 1'b0;
        wb_in_valid = 1'b0;
        wb_in.addr = ctl_reg.d_addr;
        wb_in.data = ctl_reg.d_wdata;
        wb_in.be = ctl_reg.d_be;
        case (ctl_reg.st)
            dmc_pkg::ST_IDLE: begin
                // both caches take a reference in the same cycle
                if (accept) begin
                    ctl_next.st = dmc_pkg::ST_LOOKUP;
                    ctl_next.i_pend = IF_REQ_I;
                    ctl_next.i_miss = 1'b0;
                    ctl_next.d_pend = DC_REQ_I;
                    ctl_next.i_addr = IF_ADDR_I;
                    ctl_next.d_addr = DC_ADDR_I;
                    ctl_next.d_we = DC_WE_I;
                    ctl_next.d_be = DC_BE_I;
                    ctl_next.d_unc = DC_UNCACHED_I;
                    ctl_next.d_wdata = DC_WDATA_I;
                    ctl_next.fill_cnt = 2'h0;
                end
            end
            dmc_pkg::ST_LOOKUP: begin
                if (ctl_reg.d_pend && ctl_reg.d_we) begin
                    // partial store: lookup result decides the merge
                    if (d_partial && d_hit && !ctl_reg.d_unc) begin
                        wb_in.data = merged;
                        wb_in.be = dmc_pkg::BE_FULL;
                    end
                    wb_in_valid = 1'b1;
                    // a full buffer holds the store here, core stalls
                    if (wb_in_ready) begin
                        ctl_next.d_pend = 1'b0;
                        ctl_next.d_valid = 1'b1;
                        // uncached or partial miss leaves cache alone
                        dc_we = !ctl_reg.d_unc && (!d_partial || d_hit);
                    end
                end else if (ctl_reg.d_pend) begin
                    if (d_hit && !ctl_reg.d_unc) begin
                        ctl_next.d_pend = 1'b0;
                        ctl_next.d_valid = 1'b1;
                        ctl_next.d_data = d_rd_data;
                    end
                end
                if (ctl_reg.i_pend && !ctl_reg.i_miss) begin
                    if (i_hit) begin
                        ctl_next.i_pend = 1'b0;
                        ctl_next.i_valid = 1'b1;
                        ctl_next.i_data = i_rd_data;
                    end else begin
                        ctl_next.i_miss = 1'b1;
                    end
                end
                // data misses are resolved before instruction misses
                if (ctl_next.d_pend && !ctl_reg.d_we) begin
                    ctl_next.st = dmc_pkg::ST_DFILL;
                end else if (ctl_next.d_pend) begin
                    ctl_next.st = dmc_pkg::ST_LOOKUP;
                end else if (ctl_next.i_pend) begin
                    ctl_next.st = dmc_pkg::ST_IFILL;
                end else begin
                    ctl_next.st = dmc_pkg::ST_IDLE;
                end
            end
            dmc_pkg::ST_DFILL: begin
                // read waits for an empty buffer so it never passes a write
                if (MR_ACK_I && wb_empty) begin
                    ctl_next.d_pend = 1'b0;
                    ctl_next.d_valid = 1'b1;
                    ctl_next.d_data = MR_DATA_I;
                    dc_wdata = MR_DATA_I;
                    dc_we = !ctl_reg.d_unc;
                    ctl_next.st = ctl_reg.i_pend ? dmc_pkg::ST_IFILL : dmc_pkg::ST_IDLE;
                end
            end
            dmc_pkg::ST_IFILL: begin
                if (MR_ACK_I && wb_empty) begin
                    ic_we = 1'b1;
                    ctl_next.fill_cnt = ctl_reg.fill_cnt + 2'h1;
                    if (ctl_reg.fill_cnt == ctl_reg.i_addr[3:2]) begin
                        ctl_next.i_valid = 1'b1;
                        ctl_next.i_data = MR_DATA_I;
                    end
                    // tag made valid only once all four words are in
                    if (ctl_reg.fill_cnt == dmc_pkg::FILL_LAST) begin
                        ic_tag_we = 1'b1;
                        ctl_next.i_pend = 1'b0;
                        ctl_next.st = dmc_pkg::ST_IDLE;
                    end
                end
            end
            default: begin
                ctl_next.st = dmc_pkg::ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctl_reg <= '0;
        end else begin
            ctl_reg <= ctl_next;
        end
    end

    // ============================================================
    // write buffer
    dmc_wbuf u_wbuf (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .in_valid_i(wb_in_valid),
        .in_ready_o(wb_in_ready),
        .in_data_i(wb_in),
        .out_valid_o(MW_REQ_O),
        .out_ready_i(MW_ACK_I),
        .out_data_o(wb_out),
        .empty_o(wb_empty)
    );

    // ============================================================
    // outputs
    assign MW_ADDR_O = wb_out.addr;
    assign MW_DATA_O = wb_out.data;
    assign MW_BE_O = wb_out.be;
    assign IF_VALID_O = ctl_reg.i_valid;
    assign IF_DATA_O = ctl_reg.i_data;
    assign DC_VALID_O = ctl_reg.d_valid;
    assign DC_RDATA_O = ctl_reg.d_data;
    assign CORE_STALL_O = (ctl_reg.st != dmc_pkg::ST_IDLE);
    assign MR_REQ_O = wb_empty && ((ctl_reg.st == dmc_pkg::ST_DFILL) ||
                                   (ctl_reg.st == dmc_pkg::ST_IFILL));
    assign MR_QUAD_O = (ctl_reg.st == dmc_pkg::ST_IFILL);
    assign MR_ADDR_O = MR_QUAD_O ? {ctl_reg.i_addr[31:4], 4'h0} : ctl_reg.d_addr;

    // ============================================================
    // checks
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!NRST_I);

    sequence s_ifetch_lookup;
        ctl_reg.st == dmc_pkg::ST_LOOKUP && ctl_reg.i_pend && !ctl_reg.i_miss;
    endsequence
    sequence s_partial_push;
        ctl_reg.st == dmc_pkg::ST_LOOKUP && ctl_reg.d_pend && ctl_reg.d_we &&
            d_partial && !ctl_reg.d_unc && wb_in_ready;
    endsequence

    a_ihit_word_out: assert property (
        (s_ifetch_lookup and i_hit) |=> IF_VALID_O && IF_DATA_O == $past(i_rd_data))
        else $error("instruction hit not delivered");
    a_imiss_stall_core: assert property (
        (s_ifetch_lookup and !i_hit) |=> !IF_VALID_O && CORE_STALL_O)
        else $error("instruction miss did not stall");
    a_invalid_no_hit: assert property (
        (ctl_reg.st == dmc_pkg::ST_LOOKUP && ctl_reg.d_pend && !ctl_reg.d_we && !d_rd_vld)
            |=> !DC_VALID_O)
        else $error("invalid entry gave a data hit");
    a_store_both_ways: assert property (
        (ctl_reg.st == dmc_pkg::ST_LOOKUP && ctl_reg.d_pend && ctl_reg.d_we &&
            !d_partial && !ctl_reg.d_unc && wb_in_ready) |-> dc_we && wb_in_valid)
        else $error("cacheable store not written through");
    a_uncached_bypass: assert property (
        (ctl_reg.st == dmc_pkg::ST_LOOKUP && ctl_reg.d_unc) |-> !dc_we)
        else $error("uncached store changed the cache");
    a_partial_hit_full: assert property (
        (s_partial_push and d_hit) |-> wb_in.be == 4'hF && dc_we && wb_in.data == merged)
        else $error("partial hit not sent as full word");
    a_partial_miss_mem: assert property (
        (s_partial_push and !d_hit) |-> !dc_we && wb_in.be == ctl_reg.d_be)
        else $error("partial miss touched the cache");
    a_quad_fill_line: assert property (
        (ctl_reg.st == dmc_pkg::ST_IFILL && MR_ACK_I && wb_empty &&
            ctl_reg.fill_cnt == 2'h3) |-> ic_tag_we ##1 !CORE_STALL_O)
        else $error("quad fill did not close the line");
endmodule : dmc_cache_top

//--- verif/dmc_mem_model.sv
`timescale 1ns/100ps
// ============================================================
// memory side: slow single and quad reads, slow write acceptance
module dmc_mem_model (
    input wire logic CLK_I,
    input wire logic NRST_I,
    input wire logic MR_REQ_I,
    input wire logic MR_QUAD_I,
    input wire logic [31:0] MR_ADDR_I,
    output logic MR_ACK_O,
    output logic [31:0] MR_DATA_O,
    input wire logic MW_REQ_I,
    input wire logic [31:0] MW_ADDR_I,
    input wire logic [31:0] MW_DATA_I,
    input wire logic [3:0] MW_BE_I,
    output logic MW_ACK_O
);
    dmc_pkg::dmc_wr_t wlog[$]; // writes taken, oldest first
    logic [3:0] rc; // read wait count
    logic [3:0] wc; // write wait count, slow so the buffer can fill
    logic [1:0] k; // word offset within a quad
    // memory content is a fixed pattern of the address
    function automatic logic [31:0] mem_word(input logic [31:0] a);
        return {a[15:0], ~a[31:16]};
    endfunction : mem_word
    // reads: one word every fourth cycle, bus scrambled between words
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            {MR_ACK_O, MR_DATA_O, rc, k} <= '0;
        end else if (MR_ACK_O) begin
            MR_ACK_O <= 1'b0;
            MR_DATA_O <= ~MR_DATA_O;
            rc <= 4'h0;
            k <= MR_QUAD_I ? k + 2'h1 : 2'h0;
        end else if (MR_REQ_I && rc == 4'h2) begin
            MR_ACK_O <= 1'b1;
            MR_DATA_O <= mem_word(MR_ADDR_I + {28'h0, k, 2'h0});
        end else begin
            rc <= MR_REQ_I ? rc + 4'h1 : 4'h0;
            MR_DATA_O <= ~MR_DATA_O; // released bus toggles between old word and its inverse
        end
    end
    // writes: accept the head after a long wait, log it
    always @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            {MW_ACK_O, wc} <= '0;
            wlog.delete();
        end else if (MW_ACK_O) begin
            MW_ACK_O <= 1'b0;
            wc <= 4'h0;
            wlog.push_back({MW_ADDR_I, MW_DATA_I, MW_BE_I});
        end else begin
            MW_ACK_O <= MW_REQ_I && wc == 4'hA;
            wc <= MW_REQ_I ? wc + 4'h1 : 4'h0;
        end
    end
endmodule : dmc_mem_model

//--- verif/tb_top.sv
`timescale 1ns/100ps
// ============================================================
// bench: reset, row table, then buffer burst and size cases
module tb_top;
    typedef struct packed {
        logic [2:0] op; // 4 fetch, 2 store, 1 uncached
        logic [3:0] be;
        logic [31:0] addr, wd, exp;
        logic [3:0] xbe; // byte enables expected at memory
        logic hit; // answer in two cycles
    } dmc_row_t;
    logic clk, nrst, alt, ifr, dr, dwe, dunc, ifv, dv, stall, mrr, mrq, mrk, mwr, mwk;
    logic [3:0] dbe, mwb;
    logic [31:0] ifa, ifd, da, dwd, drd, mra, mrd, mwa, mwd;
    int fail_count = 0;
    int checked = 0;
    int cyc = 0;
    int n, i;
    dmc_row_t rows[16];
    dmc_cache_top uut (.CLK_I(clk), .NRST_I(nrst), .ALT_SIZE_I(alt), .IF_REQ_I(ifr),
        .IF_ADDR_I(ifa), .IF_VALID_O(ifv), .IF_DATA_O(ifd), .DC_REQ_I(dr), .DC_WE_I(dwe),
        .DC_BE_I(dbe), .DC_UNCACHED_I(dunc), .DC_ADDR_I(da), .DC_WDATA_I(dwd),
        .DC_VALID_O(dv), .DC_RDATA_O(drd), .CORE_STALL_O(stall), .MR_REQ_O(mrr),
        .MR_QUAD_O(mrq), .MR_ADDR_O(mra), .MR_ACK_I(mrk), .MR_DATA_I(mrd),
        .MW_REQ_O(mwr), .MW_ADDR_O(mwa), .MW_DATA_O(mwd), .MW_BE_O(mwb), .MW_ACK_I(mwk));
    dmc_mem_model u_mem (.CLK_I(clk), .NRST_I(nrst), .MR_REQ_I(mrr), .MR_QUAD_I(mrq),
        .MR_ADDR_I(mra), .MR_ACK_O(mrk), .MR_DATA_O(mrd), .MW_REQ_I(mwr),
        .MW_ADDR_I(mwa), .MW_DATA_I(mwd), .MW_BE_I(mwb), .MW_ACK_O(mwk));
    // expected memory word of an address
    function automatic logic [31:0] mw(input logic [31:0] a);
        return {a[15:0], ~a[31:16]};
    endfunction : mw
    task automatic chk(input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk
    task automatic chk_wr(input dmc_pkg::dmc_wr_t e, input dmc_pkg::dmc_wr_t g);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask : chk_wr
    task automatic test_done;
        $display("checked=%0d fail_count=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done
    // one core reference, entered just after an edge
    task automatic do_op(input dmc_row_t r);
        n = 0;
        while (stall !== 1'b0 && n < 99) begin
            @(posedge clk);
            #1 n++;
        end
        {ifr, ifa, dr, dwe, dunc} = {r.op[2], r.addr, ~r.op[2], r.op[1], r.op[0]};
        {dbe, da, dwd} = {r.be, r.addr, r.wd};
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
            {ifr, dr} = 2'h0; // taken at the first edge
        end while ((r.op[2] ? ifv : dv) !== 1'b1 && n < 99);
        chk({31'h0, r.hit}, {31'h0, n == 2});
        if (!r.op[1]) chk(r.exp, r.op[2] ? ifd : drd);
        $display("op %h ended after %0d cycles", r.addr, n);
    endtask : do_op
    task automatic wait_log(input int cnt);
        n = 0;
        while (u_mem.wlog.size() < cnt && n < 300) begin
            @(posedge clk);
            #1 n++;
        end
    endtask : wait_log
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // hang guard: the whole run needs well under this many cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            test_done();
        end
    end
    initial begin
        {nrst, alt, ifr, dr, dwe, dunc, dbe, ifa, da, dwd} = '0;
        rows[0] = '{3'h0, 4'hF, 32'h2010, 32'h0, mw(32'h2010), 4'hF, 1'b0};
        rows[1] = '{3'h0, 4'hF, 32'h2010, 32'h0, mw(32'h2010), 4'hF, 1'b1};
        rows[2] = '{3'h2, 4'hF, 32'h2010, 32'h11223344, 32'h11223344, 4'hF, 1'b1};
        rows[3] = '{3'h0, 4'hF, 32'h2010, 32'h0, 32'h11223344, 4'hF, 1'b1};
        rows[4] = '{3'h2, 4'h1, 32'h2010, 32'hAABBCCDD, 32'h112233DD, 4'hF, 1'b1};
        rows[5] = '{3'h0, 4'hF, 32'h2010, 32'h0, 32'h112233DD, 4'hF, 1'b1};
        rows[6] = '{3'h2, 4'h2, 32'h2020, 32'h55667788, 32'h55667788, 4'h2, 1'b1};
        rows[7] = '{3'h0, 4'hF, 32'h2020, 32'h0, mw(32'h2020), 4'hF, 1'b0};
        rows[8] = '{3'h3, 4'hF, 32'h2010, 32'h99AABBCC, 32'h99AABBCC, 4'hF, 1'b1};
        rows[9] = '{3'h0, 4'hF, 32'h2010, 32'h0, 32'h112233DD, 4'hF, 1'b1};
        rows[10] = '{3'h0, 4'hF, 32'h3010, 32'h0, mw(32'h3010), 4'hF, 1'b0};
        rows[11] = '{3'h0, 4'hF, 32'h2010, 32'h0, mw(32'h2010), 4'hF, 1'b0};
        rows[12] = '{3'h4, 4'hF, 32'h4108, 32'h0, mw(32'h4108), 4'hF, 1'b0};
        rows[13] = '{3'h4, 4'hF, 32'h4100, 32'h0, mw(32'h4100), 4'hF, 1'b1};
        rows[14] = '{3'h4, 4'hF, 32'h410C, 32'h0, mw(32'h410C), 4'hF, 1'b1};
        rows[15] = '{3'h0, 4'hF, 32'h4100, 32'h0, mw(32'h4100), 4'hF, 1'b0};
        repeat (20) @(posedge clk);
        #1 nrst = 1'b1;
        chk(32'h0, {27'h0, stall, mrr, mwr, ifv, dv});
        for (i = 0; i < 16; i++) begin
            do_op(rows[i]);
            if (rows[i].op[1]) begin
                wait_log(1);
                chk_wr({rows[i].addr, rows[i].exp, rows[i].xbe}, u_mem.wlog[0]);
                u_mem.wlog.delete();
            end
        end
        // back-to-back stores: fifth waits for a free slot
        for (i = 0; i < 5; i++) begin
            do_op('{3'h3, 4'hF, 32'(32'h100 + i * 4), 32'(i), 32'h0, 4'hF, i < 4});
        end
        wait_log(5);
        for (i = 0; i < 5; i++) begin
            chk_wr({32'(32'h100 + i * 4), 32'(i), 4'hF}, u_mem.wlog[i]);
        end
        // uncached load of a cached word: memory answers, cache word survives
        do_op('{3'h2, 4'hF, 32'h2040, 32'h600DF00D, 32'h0, 4'hF, 1'b1});
        do_op('{3'h1, 4'hF, 32'h2040, 32'h0, mw(32'h2040), 4'hF, 1'b0});
        do_op('{3'h0, 4'hF, 32'h2040, 32'h0, 32'h600DF00D, 4'hF, 1'b1});
        // alternative sizes: these two words no longer share an entry
        nrst = 1'b0;
        alt = 1'b1;
        repeat (2) @(posedge clk);
        #1 nrst = 1'b1;
        do_op('{3'h0, 4'hF, 32'h2010, 32'h0, mw(32'h2010), 4'hF, 1'b0});
        do_op('{3'h0, 4'hF, 32'h3010, 32'h0, mw(32'h3010), 4'hF, 1'b0});
        do_op('{3'h0, 4'hF, 32'h2010, 32'h0, mw(32'h2010), 4'hF, 1'b1});
        test_done();
    end
endmodule : tb_top
